// >>> rtl/radio_spi_command_engine.sv
`timescale 1ns/1ps
// Behaviour
// - chip select falling edge starts a fresh command byte.
// - status byte shifts out while the command byte shifts in.
// - command MSB first; data bytes LSByte first, MSB first each.
// - pattern 000 plus address reads up to five register bytes.
// - pattern 001 plus address writes bytes; only when not active.
// - payload read starts at byte 0, then leaves the receive FIFO.
// - payload write stores bytes into transmit FIFO from byte 0.
// - flush transmit empties the whole transmit FIFO.
// - flush receive empties receive FIFO; not during acknowledge.
// - resend repeats last payload until new write or flush.
// - width query returns top receive entry width; host flushes if big.
// - acknowledge payload for pipes 0-5; three pending, in order.
// - no-ack payload write; that packet waits for no acknowledge.
// - all-ones command does nothing but return status.
// - short register write changes only received bytes.
// - pipe number field updates on interrupt falling transition.
// - retries above limit raise event, stop, keep payload.
// - host retries by toggling radio enable, or flushes.
// - receiver ack-payload sent event waits for next new packet.
// - transmitter ack with payload raises sent and received events.
// - receiver drops duplicate packet id without received event.
// - interrupt active low from three masked events; enable active high.
// - writing one to an event bit clears it and the interrupt.
// - mask bit high keeps its event off the interrupt; all unmasked after reset.
module radio_spi_command_engine
  import radio_spi_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_RESET,
  input  wire logic       I_CSN,
  input  wire logic       I_SCK,
  input  wire logic       I_MOSI,
  output logic            O_MISO,
  input  wire logic       I_CE,
  output logic            O_IRQ_N,
  input  wire logic       I_RX_VALID,
  input  wire logic [7:0] I_RX_DATA,
  input  wire logic       I_RX_DONE,
  input  wire logic [2:0] I_RX_PIPE,
  input  wire logic [1:0] I_RX_PID,
  input  wire logic       I_ACK_RX,
  input  wire logic       I_ACK_HAS_PL,
  input  wire logic       I_ACK_TIMEOUT,
  input  wire logic       I_TX_SENT,
  input  wire logic [4:0] I_TX_RD_IDX,
  output logic [7:0]      O_TX_RD_DATA,
  output logic [5:0]      O_TX_LEN,
  output logic [2:0]      O_TX_PIPE,
  output logic            O_TX_NOACK,
  output logic            O_TX_READY,
  output logic            O_PWR_UP,
  output logic            O_PRIM_RX,
  output logic [3:0]      O_RETRANSMIT_COUNT
);
  typedef struct packed {
    logic [1:0] ce_s;
    logic       ce_p;
    cmd_state_t st;
    logic [4:0] addr;
    logic [5:0] idx;
    logic [2:0] wr_pipe;
    logic       wr_noack;
    logic [NUM_REGS-1:0][REG_BYTES-1:0][7:0] regs;
    logic [2:0] evt;
    logic [2:0] pipe_no;
    logic       irq_n;
    logic [DEPTH-1:0][PL_MAX-1:0][7:0] tx_mem;
    logic [DEPTH-1:0][5:0] tx_len;
    logic [DEPTH-1:0][2:0] tx_pipe;
    logic [DEPTH-1:0]      tx_noack;
    logic [1:0] tx_head;
    logic [1:0] tx_cnt;
    logic [DEPTH-1:0][PL_MAX-1:0][7:0] rx_mem;
    logic [DEPTH-1:0][5:0] rx_len;
    logic [DEPTH-1:0][2:0] rx_pipe;
    logic [1:0] rx_head;
    logic [1:0] rx_cnt;
    logic [5:0] rx_wr_idx;
    logic [5:0][1:0] last_pid;
    logic [5:0] pid_seen;
    logic [3:0] retransmit_count;
    logic       hold;
    logic       reuse;
    logic       ack_pend;
    logic [7:0] tx_rd_data;
  } engine_t;

  engine_t st_q;
  engine_t st_d;
  spi_byte_if bus ();

  spi_byte_shifter u_shifter (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_csn   (I_CSN),
    .i_sck   (I_SCK),
    .i_mosi  (I_MOSI),
    .o_miso  (O_MISO),
    .bus     (bus)
  );

  function automatic logic [1:0] slot(input logic [1:0] h,
                                      input logic [1:0] n);
    logic [2:0] s;
    s = {1'b0, h} + {1'b0, n};
    slot = (s >= {1'b0, DEPTH_CNT}) ? 2'(s - {1'b0, DEPTH_CNT}) : s[1:0];
  endfunction

  logic [7:0] cfg;
  logic [7:0] status;
  logic [2:0] mask;
  logic       active;
  logic       tx_full;
  logic       cmd_byte;
  assign cfg     = st_q.regs[REG_CONFIG][0];
  assign mask    = {cfg[BIT_MASK_RX], cfg[BIT_MASK_TX], cfg[BIT_MASK_MAX]};
  assign tx_full = st_q.tx_cnt == DEPTH_CNT;
  assign status  = {1'b0, st_q.evt, st_q.pipe_no, tx_full};
  assign active  = cfg[BIT_PWR_UP] & st_q.ce_s[1];
  assign cmd_byte = bus.rx_valid && st_q.st == ST_CMD;

  // byte presented to the shifter for the next MISO byte
  always_comb begin
    bus.tx_byte = 8'h00;
    case (st_q.st)
      ST_CMD: bus.tx_byte = status;
      ST_REG_RD: begin
        if (st_q.addr == REG_STATUS) begin
          bus.tx_byte = status;
        end else if (st_q.idx < REG_LEN) begin
          bus.tx_byte = st_q.regs[st_q.addr][st_q.idx[2:0]];
        end
      end
      ST_RX_RD: bus.tx_byte = st_q.rx_mem[st_q.rx_head][st_q.idx[4:0]];
      ST_WIDTH: bus.tx_byte = {2'h0, st_q.rx_len[st_q.rx_head]};
      default:  bus.tx_byte = 8'h00;
    endcase
  end

  logic       tx_push;
  logic       tx_pop;
  logic       tx_flush;
  logic       rx_push;
  logic       rx_pop;
  logic       rx_flush;
  logic       dup;
  logic [1:0] tx_tail;
  logic [1:0] rx_tail;

  always_comb begin
    st_d     = st_q;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    tx_flush = 1'b0;
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    rx_flush = 1'b0;
    dup      = 1'b0;
    tx_tail  = slot(st_q.tx_head, st_q.tx_cnt);
    rx_tail  = slot(st_q.rx_head, st_q.rx_cnt);
    st_d.ce_s = {st_q.ce_s[0], I_CE};
    st_d.ce_p = st_q.ce_s[1];

    // host side
    if (bus.start) begin
      st_d.st  = ST_CMD;
      st_d.idx = 6'h00;
    end else if (cmd_byte) begin
      st_d.st = ST_IGNORE;
      if (bus.rx_byte[7:5] == CMD_REG_READ) begin
        st_d.st   = ST_REG_RD;
        st_d.addr = bus.rx_byte[4:0];
      end else if (bus.rx_byte[7:5] == CMD_REG_WRITE) begin
        // writes during active radio modes are dropped
        if (!active) begin
          st_d.st = ST_REG_WR;
        end
        st_d.addr = bus.rx_byte[4:0];
      end else if (bus.rx_byte == CMD_RX_READ) begin
        st_d.st = ST_RX_RD;
      end else if (bus.rx_byte == CMD_TX_WRITE ||
                   bus.rx_byte == CMD_TX_NOACK) begin
        st_d.reuse = 1'b0;
        if (!tx_full) begin
          st_d.st = ST_TX_WR;
        end
        st_d.wr_noack = bus.rx_byte == CMD_TX_NOACK;
        st_d.wr_pipe  = 3'h0;
      end else if (bus.rx_byte[7:3] == CMD_ACK_PL &&
                   bus.rx_byte[2:0] <= PIPE_MAX) begin
        if (!tx_full) begin
          st_d.st = ST_TX_WR;
        end
        st_d.wr_noack = 1'b0;
        st_d.wr_pipe  = bus.rx_byte[2:0];
      end else if (bus.rx_byte == CMD_FLUSH_TX) begin
        tx_flush = 1'b1;
      end else if (bus.rx_byte == CMD_FLUSH_RX) begin
        rx_flush = 1'b1;
      end else if (bus.rx_byte == CMD_RESEND) begin
        st_d.reuse = 1'b1;
        if (st_q.tx_cnt == 2'h0) begin
          st_d.tx_head = slot(st_q.tx_head, 2'h2);
          st_d.tx_cnt  = 2'h1;
        end
      end else if (bus.rx_byte == CMD_WIDTH) begin
        st_d.st = ST_WIDTH;
      end
    end else if (bus.rx_valid) begin
      if (st_q.idx != 6'h3F) begin
        st_d.idx = st_q.idx + 6'h01;
      end
      // each byte lands as it arrives, so a short write leaves the rest
      if (st_q.st == ST_REG_WR && st_q.idx < REG_LEN) begin
        if (st_q.addr == REG_STATUS) begin
          st_d.evt = st_q.evt & ~bus.rx_byte[6:4];
        end else begin
          st_d.regs[st_q.addr][st_q.idx[2:0]] = bus.rx_byte;
        end
      end
      if (st_q.st == ST_TX_WR && st_q.idx < PL_MAX_LEN) begin
        st_d.tx_mem[tx_tail][st_q.idx[4:0]] = bus.rx_byte;
      end
    end else if (bus.stop) begin
      st_d.st = ST_CMD;
      if (st_q.st == ST_RX_RD && st_q.idx != 6'h00 &&
          st_q.rx_cnt != 2'h0) begin
        rx_pop = 1'b1;
      end
      if (st_q.st == ST_TX_WR && st_q.idx != 6'h00) begin
        tx_push = 1'b1;
        st_d.tx_len[tx_tail] = (st_q.idx > PL_MAX_LEN) ?
                               PL_MAX_LEN : st_q.idx;
        st_d.tx_noack[tx_tail] = st_q.wr_noack;
        st_d.tx_pipe[tx_tail]  = st_q.wr_pipe;
      end
    end

    // radio side; event sets come after host clears so a set wins
    if (I_RX_VALID) begin
      if (st_q.rx_cnt != DEPTH_CNT && st_q.rx_wr_idx < PL_MAX_LEN) begin
        st_d.rx_mem[rx_tail][st_q.rx_wr_idx[4:0]] = I_RX_DATA;
      end
      if (st_q.rx_wr_idx != 6'h3F) begin
        st_d.rx_wr_idx = st_q.rx_wr_idx + 6'h01;
      end
    end
    if (I_RX_DONE) begin
      st_d.rx_wr_idx = 6'h00;
      dup = cfg[BIT_PRIM_RX] && st_q.pid_seen[I_RX_PIPE] &&
            st_q.last_pid[I_RX_PIPE] == I_RX_PID;
      if (!dup && st_q.rx_cnt != DEPTH_CNT) begin
        rx_push = 1'b1;
        st_d.rx_len[rx_tail]  = (st_q.rx_wr_idx > PL_MAX_LEN) ?
                                PL_MAX_LEN : st_q.rx_wr_idx;
        st_d.rx_pipe[rx_tail] = I_RX_PIPE;
        st_d.evt[EVT_RX]      = 1'b1;
        st_d.pid_seen[I_RX_PIPE] = 1'b1;
        st_d.last_pid[I_RX_PIPE] = I_RX_PID;
        if (st_q.ack_pend) begin
          st_d.evt[EVT_TX] = 1'b1;
          st_d.ack_pend    = 1'b0;
        end
      end
    end
    if (I_ACK_RX && !cfg[BIT_PRIM_RX]) begin
      st_d.evt[EVT_TX] = 1'b1;
      if (I_ACK_HAS_PL) begin
        st_d.evt[EVT_RX] = 1'b1;
      end
      tx_pop       = !st_q.reuse && st_q.tx_cnt != 2'h0;
      st_d.retransmit_count = 4'h0;
    end
    if (I_ACK_TIMEOUT && !cfg[BIT_PRIM_RX]) begin
      if (st_q.retransmit_count >= st_q.regs[REG_RETRY][0][3:0]) begin
        st_d.evt[EVT_MAX] = 1'b1;
        st_d.hold         = 1'b1;
      end else begin
        st_d.retransmit_count = st_q.retransmit_count + 4'h1;
      end
    end
    if (I_TX_SENT && st_q.tx_cnt != 2'h0) begin
      if (cfg[BIT_PRIM_RX]) begin
        tx_pop        = 1'b1;
        st_d.ack_pend = 1'b1;
      end else if (st_q.tx_noack[st_q.tx_head]) begin
        st_d.evt[EVT_TX] = 1'b1;
        tx_pop           = !st_q.reuse;
      end
    end
    // a fresh enable edge retries the retained packet
    if (st_q.ce_s[1] && !st_q.ce_p) begin
      st_d.hold    = 1'b0;
      st_d.retransmit_count = 4'h0;
    end

    // fifo bookkeeping
    if (tx_flush) begin
      st_d.tx_cnt  = 2'h0;
      st_d.reuse   = 1'b0;
      st_d.hold    = 1'b0;
      st_d.retransmit_count = 4'h0;
    end else begin
      if (tx_pop) begin
        st_d.tx_head = slot(st_q.tx_head, 2'h1);
      end
      st_d.tx_cnt = st_d.tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};
    end
    if (rx_flush) begin
      st_d.rx_cnt = 2'h0;
    end else begin
      if (rx_pop) begin
        st_d.rx_head = slot(st_q.rx_head, 2'h1);
      end
      st_d.rx_cnt = st_q.rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
    end

    st_d.irq_n = ~|(st_d.evt & ~mask);
    if (st_q.irq_n && !st_d.irq_n) begin
      // pipe field only moves on the falling interrupt edge
      st_d.pipe_no = (st_d.rx_cnt != 2'h0) ?
                     st_d.rx_pipe[st_d.rx_head] : PIPE_NONE;
    end
    st_d.tx_rd_data = st_q.tx_mem[st_q.tx_head][I_TX_RD_IDX];

    if (I_RESET) begin
      st_d    = '0;
      st_d.st = ST_CMD;
      st_d.regs[REG_CONFIG][0] = CONFIG_RST;
      st_d.irq_n   = 1'b1;
      st_d.pipe_no = PIPE_NONE;
    end
  end

  always_ff @(posedge I_CLK) begin
    st_q <= st_d;
  end

  assign O_IRQ_N            = st_q.irq_n;
  assign O_TX_RD_DATA       = st_q.tx_rd_data;
  assign O_TX_LEN           = st_q.tx_len[st_q.tx_head];
  assign O_TX_PIPE          = st_q.tx_pipe[st_q.tx_head];
  assign O_TX_NOACK         = st_q.tx_noack[st_q.tx_head];
  assign O_PWR_UP           = cfg[BIT_PWR_UP];
  assign O_PRIM_RX          = cfg[BIT_PRIM_RX];
  assign O_RETRANSMIT_COUNT = st_q.retransmit_count;
  // enable is active high and gates readiness in transmit mode only
  assign O_TX_READY = (st_q.tx_cnt != 2'h0) && (cfg[BIT_PRIM_RX] ||
                      (active && !st_q.hold));

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  sequence s_cmd(logic [7:0] c);
    bus.rx_valid && st_q.st == ST_CMD && bus.rx_byte == c;
  endsequence
  sequence s_rd_end;
    bus.stop && st_q.st == ST_RX_RD && st_q.idx != 6'h00 &&
    st_q.rx_cnt != 2'h0 && !I_RX_DONE;
  endsequence

  a_fresh_command: assert property (
    bus.start |=> st_q.st == ST_CMD && st_q.idx == 6'h00)
    else $error("command state not fresh after select");
  a_status_first: assert property (
    bus.start |=> bus.tx_byte == status)
    else $error("status byte not presented first");
  a_reg_read: assert property (
    bus.rx_valid && st_q.st == ST_CMD && bus.rx_byte[7:5] == CMD_REG_READ
    |=> st_q.st == ST_REG_RD && st_q.addr == $past(bus.rx_byte[4:0]))
    else $error("register read not entered");
  a_rx_pop: assert property (
    s_rd_end |=> st_q.rx_cnt == $past(st_q.rx_cnt) - 2'h1)
    else $error("read payload not removed");
  a_flush_tx: assert property (
    s_cmd(CMD_FLUSH_TX) |=> st_q.tx_cnt == 2'h0 && !st_q.reuse)
    else $error("transmit fifo not emptied");
  a_flush_rx: assert property (
    s_cmd(CMD_FLUSH_RX) |=> st_q.rx_cnt == 2'h0)
    else $error("receive fifo not emptied");
  a_status_only: assert property (
    s_cmd(CMD_STATUS_ONLY) |=> st_q.st == ST_IGNORE &&
    $stable(st_q.regs) [*2])
    else $error("status-only command had an effect");
  a_max_retry: assert property (
    I_ACK_TIMEOUT && !cfg[BIT_PRIM_RX] && !bus.rx_valid && !bus.stop &&
    st_q.retransmit_count >= st_q.regs[REG_RETRY][0][3:0]
    |=> st_q.evt[EVT_MAX] && st_q.hold && !O_TX_READY &&
    st_q.tx_cnt == $past(st_q.tx_cnt))
    else $error("retry limit did not stop and keep payload");
  a_ack_payload: assert property (
    I_ACK_RX && I_ACK_HAS_PL && !cfg[BIT_PRIM_RX]
    |=> st_q.evt[EVT_RX] && st_q.evt[EVT_TX])
    else $error("ack payload did not raise both events");
  a_dup_drop: assert property (
    I_RX_DONE && dup |=> st_q.rx_cnt == $past(st_q.rx_cnt) ||
    $past(rx_pop) || $past(rx_flush))
    else $error("duplicate packet was stored");
  a_pipe_update: assert property (
    !$stable(st_q.pipe_no) |-> $fell(O_IRQ_N) || $past(I_RESET))
    else $error("pipe field moved without interrupt edge");
  a_irq_masked: assert property (
    $rose(st_q.evt[EVT_RX]) && !mask[EVT_RX] |-> !O_IRQ_N)
    else $error("unmasked event did not drive interrupt");
endmodule

// >>> rtl/radio_spi_pkg.sv
package radio_spi_pkg;
  localparam int PL_MAX    = 32;
  localparam int DEPTH     = 3;
  localparam int REG_BYTES = 5;
  localparam int NUM_REGS  = 32;
  localparam logic [5:0] PL_MAX_LEN = 6'h20;
  localparam logic [5:0] REG_LEN    = 6'h05;
  localparam logic [1:0] DEPTH_CNT  = 2'h3;
  // command words
  localparam logic [2:0] CMD_REG_READ    = 3'h0;
  localparam logic [2:0] CMD_REG_WRITE   = 3'h1;
  localparam logic [7:0] CMD_RX_READ     = 8'h61;
  localparam logic [7:0] CMD_TX_WRITE    = 8'hA0;
  localparam logic [7:0] CMD_TX_NOACK    = 8'hB0;
  localparam logic [4:0] CMD_ACK_PL      = 5'h15;
  localparam logic [7:0] CMD_FLUSH_TX    = 8'hE1;
  localparam logic [7:0] CMD_FLUSH_RX    = 8'hE2;
  localparam logic [7:0] CMD_RESEND      = 8'hE3;
  localparam logic [7:0] CMD_WIDTH       = 8'h60;
  localparam logic [7:0] CMD_STATUS_ONLY = 8'hFF;
  localparam logic [2:0] PIPE_MAX        = 3'h5;
  localparam logic [2:0] PIPE_NONE       = 3'h7;
  // register addresses
  localparam logic [4:0] REG_CONFIG = 5'h00;
  localparam logic [4:0] REG_RETRY  = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h07;
  localparam logic [7:0] CONFIG_RST = 8'h08;
  // config bits
  localparam int BIT_MASK_RX = 6;
  localparam int BIT_MASK_TX = 5;
  localparam int BIT_MASK_MAX = 4;
  localparam int BIT_PWR_UP  = 1;
  localparam int BIT_PRIM_RX = 0;
  // event vector: [2] received, [1] sent, [0] max retries
  localparam int EVT_RX  = 2;
  localparam int EVT_TX  = 1;
  localparam int EVT_MAX = 0;
  typedef enum logic [2:0] {
    ST_CMD, ST_REG_RD, ST_REG_WR, ST_RX_RD, ST_TX_WR, ST_WIDTH, ST_IGNORE
  } cmd_state_t;
endpackage

// >>> rtl/spi_byte_if.sv
`timescale 1ns/1ps
interface spi_byte_if;
  logic       start;
  logic       stop;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  modport shifter (output start, stop, rx_valid, rx_byte, input tx_byte);
  modport engine  (input start, stop, rx_valid, rx_byte, output tx_byte);
endinterface

// >>> rtl/spi_byte_shifter.sv
`timescale 1ns/1ps
module spi_byte_shifter (
  input  wire logic   i_clk,
  input  wire logic   i_reset,
  input  wire logic   i_csn,
  input  wire logic   i_sck,
  input  wire logic   i_mosi,
  output logic        o_miso,
  spi_byte_if.shifter bus
);
  typedef struct packed {
    logic [1:0] csn_s;
    logic [1:0] sck_s;
    logic [1:0] mosi_s;
    logic       csn_p;
    logic       sck_p;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [2:0] bit_cnt;
    logic       start;
    logic       stop;
    logic       rx_valid;
    logic [7:0] rx_byte;
  } shift_t;

  shift_t s_q;
  shift_t s_d;

  always_comb begin
    s_d = s_q;
    // first stage feeds only the second stage
    s_d.csn_s  = {s_q.csn_s[0], i_csn};
    s_d.sck_s  = {s_q.sck_s[0], i_sck};
    s_d.mosi_s = {s_q.mosi_s[0], i_mosi};
    s_d.csn_p  = s_q.csn_s[1];
    s_d.sck_p  = s_q.sck_s[1];
    s_d.start    = s_q.csn_p & ~s_q.csn_s[1];
    s_d.stop     = ~s_q.csn_p & s_q.csn_s[1];
    s_d.rx_valid = 1'b0;
    if (s_d.start) begin
      s_d.tx_sh   = bus.tx_byte;
      s_d.bit_cnt = 3'h0;
    end else if (!s_q.csn_s[1]) begin
      if (!s_q.sck_p && s_q.sck_s[1]) begin
        s_d.rx_sh   = {s_q.rx_sh[6:0], s_q.mosi_s[1]};
        s_d.bit_cnt = s_q.bit_cnt + 3'h1;
        if (s_q.bit_cnt == 3'h7) begin
          s_d.rx_valid = 1'b1;
          s_d.rx_byte  = {s_q.rx_sh[6:0], s_q.mosi_s[1]};
        end
      end else if (s_q.sck_p && !s_q.sck_s[1]) begin
        // engine has had several cycles to present the next byte
        if (s_q.bit_cnt == 3'h0) begin
          s_d.tx_sh = bus.tx_byte;
        end else begin
          s_d.tx_sh = {s_q.tx_sh[6:0], 1'b0};
        end
      end
    end
    if (i_reset) begin
      s_d       = '0;
      s_d.csn_s = 2'h3;
      s_d.csn_p = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    s_q <= s_d;
  end

  assign o_miso       = s_q.tx_sh[7];
  assign bus.start    = s_q.start;
  assign bus.stop     = s_q.stop;
  assign bus.rx_valid = s_q.rx_valid;
  assign bus.rx_byte  = s_q.rx_byte;
endmodule

// >>> test/radio_spi_command_engine_tb_top.sv
`timescale 1ns/1ps
module radio_spi_command_engine_tb_top;
  import radio_spi_pkg::*;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  logic       ce = 1'h0;
  logic       csn, sck, mosi, miso, irq_n;
  logic       rx_valid = 1'h0, rx_done = 1'h0;
  logic [7:0] rx_data = 8'h00;
  logic [2:0] rx_pipe = 3'h0;
  logic [1:0] rx_pid = 2'h0;
  logic       ack_rx = 1'h0, ack_has_pl = 1'h0, ack_timeout = 1'h0;
  logic [4:0] tx_rd_idx = 5'h00;
  logic [7:0] tx_rd_data;
  logic [5:0] tx_len;
  logic       tx_noack, tx_ready, pwr_up;
  logic       tx_sent = 1'h0, prim_rx;
  logic [2:0] tx_pipe;
  logic [3:0] rtx_cnt;
  int         bad_count = 0;
  int         num_checks = 0;

  always #2.5 clk = ~clk;

  spi_host_model u_host (.o_csn(csn), .o_sck(sck), .o_mosi(mosi),
                         .i_miso(miso));

  radio_spi_command_engine u_dut (
    .I_CLK(clk), .I_RESET(rst), .I_CSN(csn), .I_SCK(sck), .I_MOSI(mosi),
    .O_MISO(miso), .I_CE(ce), .O_IRQ_N(irq_n), .I_RX_VALID(rx_valid),
    .I_RX_DATA(rx_data), .I_RX_DONE(rx_done), .I_RX_PIPE(rx_pipe),
    .I_RX_PID(rx_pid), .I_ACK_RX(ack_rx), .I_ACK_HAS_PL(ack_has_pl),
    .I_ACK_TIMEOUT(ack_timeout), .I_TX_SENT(tx_sent),
    .I_TX_RD_IDX(tx_rd_idx), .O_TX_RD_DATA(tx_rd_data), .O_TX_LEN(tx_len),
    .O_TX_PIPE(tx_pipe), .O_TX_NOACK(tx_noack), .O_TX_READY(tx_ready),
    .O_PWR_UP(pwr_up), .O_PRIM_RX(prim_rx), .O_RETRANSMIT_COUNT(rtx_cnt));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    // outputs are read half a cycle after the edge that launches them
    @(negedge clk);
  endtask

  task automatic cmd(input logic [7:0] c, input int n);
    @(posedge clk);
    u_host.xfer(c, n);
  endtask

  // little-endian byte order on the wire
  task automatic regw(input logic [4:0] a, input logic [39:0] v, input int n);
    for (int i = 0; i < n; i++) u_host.wr_buf[i] = v[8*i +: 8];
    cmd({CMD_REG_WRITE, a}, n);
  endtask

  task automatic plw(input logic [7:0] c, input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) u_host.wr_buf[i] = b + 8'(i);
    cmd(c, n);
  endtask

  task automatic status(input logic [7:0] exp);
    cmd(CMD_STATUS_ONLY, 0);
    chk("status", exp, u_host.status_q);
  endtask

  task automatic evt(input logic [2:0] v);  // {timeout, ack, has_pl}
    @(posedge clk);
    {ack_timeout, ack_rx, ack_has_pl} <= v;
    @(posedge clk);
    {ack_timeout, ack_rx, ack_has_pl} <= 3'h0;
    tick(2);
  endtask

  task automatic rx_pkt(input logic [2:0] pipe, input logic [1:0] packet_sequence_id,
                        input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1'h1;
      rx_data  <= 8'hC0 + 8'(i);
    end
    @(posedge clk);
    rx_valid <= 1'h0;
    rx_done  <= 1'h1;
    rx_pipe  <= pipe;
    rx_pid   <= packet_sequence_id;
    @(posedge clk);
    rx_done <= 1'h0;
    tick(2);
  endtask

  // whole run is near 60 us; give it ample room
  initial begin
    #300us;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    tick(9);
    @(posedge clk) rst <= 1'h0;
    tick(8);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    status(8'h0E);
    cmd({CMD_REG_READ, REG_CONFIG}, 1);
    chk("config", CONFIG_RST, u_host.rd_buf[0]);
    regw(5'h0A, 40'h55_4433_2211, 5);
    regw(5'h0A, 40'h00_0000_BBAA, 2);
    u_host.wr_buf[0] = 8'h00;
    cmd(8'h70, 1);  // unknown word must leave storage alone
    cmd({CMD_REG_READ, 5'h0A}, 5);
    for (int i = 0; i < 5; i++) begin
      chk("reg", 8'(40'h55_4433_BBAA >> (8*i)), u_host.rd_buf[i]);
    end
    plw(CMD_TX_WRITE, 3, 8'h10);
    chk("tx_len", 8'h03, {2'h0, tx_len});
    @(posedge clk) tx_rd_idx <= 5'h02;
    tick(3);
    chk("tx_byte", 8'h12, tx_rd_data);
    plw(CMD_TX_WRITE, 32, 8'h40);
    plw(CMD_TX_WRITE, 1, 8'h80);
    status(8'h0F);
    cmd(CMD_FLUSH_TX, 0);
    status(8'h0E);
    plw(CMD_TX_NOACK, 2, 8'h20);
    chk("noack", 8'h01, {7'h00, tx_noack});
    cmd(CMD_FLUSH_TX, 0);
    plw(CMD_TX_WRITE, 2, 8'h30);
    regw(REG_RETRY, 40'h00_0000_0002, 1);
    regw(REG_CONFIG, 40'h00_0000_000A, 1);
    chk("pwr_up", 8'h01, {7'h00, pwr_up});
    @(posedge clk) ce <= 1'h1;
    tick(4);
    chk("ready", 8'h01, {7'h00, tx_ready});
    regw(REG_RETRY, 40'h00_0000_0007, 1);
    cmd({CMD_REG_READ, REG_RETRY}, 1);
    chk("retry", 8'h02, u_host.rd_buf[0]);
    evt(3'h4);
    evt(3'h4);
    chk("retries", 8'h02, {4'h0, rtx_cnt});
    chk("irq_n", 8'h01, {7'h00, irq_n});
    evt(3'h4);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    chk("ready", 8'h00, {7'h00, tx_ready});
    chk("tx_len", 8'h02, {2'h0, tx_len});
    @(posedge clk) ce <= 1'h0;
    regw(REG_STATUS, 40'h00_0000_0010, 1);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    @(posedge clk) ce <= 1'h1;
    tick(4);
    chk("ready", 8'h01, {7'h00, tx_ready});
    chk("retries", 8'h00, {4'h0, rtx_cnt});
    evt(3'h3);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    chk("ready", 8'h00, {7'h00, tx_ready});
    cmd(CMD_STATUS_ONLY, 0);
    chk("ack_evts", 8'h03, {6'h00, u_host.status_q[6:5]});
    cmd(CMD_RESEND, 0);
    chk("resend", 8'h02, {2'h0, tx_len});
    evt(3'h2);
    chk("reuse", 8'h01, {7'h00, tx_ready});
    cmd(CMD_FLUSH_TX, 0);
    chk("flushed", 8'h00, {7'h00, tx_ready});
    @(posedge clk) ce <= 1'h0;
    regw(REG_CONFIG, 40'h00_0000_007A, 1);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    regw(REG_STATUS, 40'h00_0000_0070, 1);
    regw(REG_CONFIG, 40'h00_0000_000B, 1);
    chk("prim_rx", 8'h01, {7'h00, prim_rx});
    plw({CMD_ACK_PL, 3'h3}, 2, 8'h50);
    plw({CMD_ACK_PL, 3'h6}, 1, 8'h60);
    chk("ack_pipe", 8'h03, {5'h00, tx_pipe});
    chk("ready", 8'h01, {7'h00, tx_ready});
    rx_pkt(3'h3, 2'h1, 4);
    chk("irq_n", 8'h00, {7'h00, irq_n});
    status(8'h46);
    @(posedge clk) tx_sent <= 1'h1;
    @(posedge clk) tx_sent <= 1'h0;
    tick(2);
    chk("ack_sent", 8'h00, {7'h00, tx_ready});
    regw(REG_STATUS, 40'h00_0000_0040, 1);
    rx_pkt(3'h3, 2'h1, 4);
    chk("irq_n", 8'h01, {7'h00, irq_n});
    cmd(CMD_WIDTH, 1);
    chk("width", 8'h04, u_host.rd_buf[0]);
    cmd(CMD_RX_READ, 4);
    for (int i = 0; i < 4; i++) begin
      chk("rx_byte", 8'hC0 + 8'(i), u_host.rd_buf[i]);
    end
    rx_pkt(3'h3, 2'h2, 2);
    status(8'h66);
    cmd(CMD_WIDTH, 1);
    chk("width", 8'h02, u_host.rd_buf[0]);
    cmd(CMD_FLUSH_RX, 0);
    tally_and_finish();
  end
endmodule

// >>> test/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic      o_csn,
  output logic      o_sck,
  output logic      o_mosi,
  input  wire logic i_miso
);
  localparam time HALF = 32ns;
  logic [7:0] wr_buf [0:31];
  logic [7:0] rd_buf [0:31];
  logic [7:0] status_q;

  initial begin
    o_csn  = 1'h1;
    o_sck  = 1'h0;
    o_mosi = 1'h0;
  end

  // mode 0: change on fall, the device samples on rise
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      o_mosi = tx[b];
      #HALF o_sck = 1'h1;
      rx[b] = i_miso;
      #HALF o_sck = 1'h0;
    end
  endtask

  // sck stands still between frames; released mosi shows the inverse level
  task automatic xfer(input logic [7:0] cmd, input int n);
    // odd offset keeps every link edge clear of a core clock edge
    #1.25 o_csn = 1'h0;
    shift_byte(cmd, status_q);
    for (int i = 0; i < n; i++) begin
      shift_byte(wr_buf[i], rd_buf[i]);
    end
    #HALF o_csn = 1'h1;
    o_mosi = ~o_mosi;
    #(4 * HALF);
  endtask
endmodule
